/* common/fmsp_consts.vh */
// Purpose: shared constants of the four-mode serial port
// Assumes: aclk is the cpu clock, 200 MHz
// Notes:   byte offsets on the axi4-lite register bus
`ifndef FMSP_CONSTS_VH
`define FMSP_CONSTS_VH

`define FMSP_ADDR_BUF   4'h0
`define FMSP_ADDR_CTL   4'h4
`define FMSP_ADDR_RATE  4'h8

// serial_control fields
`define FMSP_CTL_RXF    0
`define FMSP_CTL_TXF    1
`define FMSP_CTL_RX9    2
`define FMSP_CTL_TX9    3
`define FMSP_CTL_REN    4
`define FMSP_CTL_FLT    5
`define FMSP_CTL_MODE   6
`define FMSP_CTL_RST    8'h00

// rate control fields
`define FMSP_RATE_DBL   0
`define FMSP_RATE_TXT2  1
`define FMSP_RATE_RXT2  2
`define FMSP_RATE_RST   3'h0

// timing: one machine cycle is six cpu clocks, 16 ticks per bit
`define FMSP_M0_LAST    3'h5
`define FMSP_OVS_LAST   4'hf
`define FMSP_OVS_MID    4'h7
`define FMSP_LEN_M0     4'h8
`define FMSP_LEN_M1     4'ha
`define FMSP_LEN_M23    4'hb

`define FMSP_RESP_OKAY  2'h0
`define FMSP_RESP_SLV   2'h2

`endif

/* src/fmsp_tx.v */
// Purpose: transmit shifter for all four frame modes
// Assumes: tick16 is the 16x bit tick, m0_shift ends a machine cycle
// Notes:   a write during a frame is queued behind it
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_tx (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] mode,
  input  wire       tick16,
  input  wire       m0_shift,
  input  wire       start,
  input  wire [7:0] data,
  input  wire       ninth,
  output wire       active,
  output wire       done,
  output wire       line
);
  reg        pend_reg;
  reg        act_reg;
  reg        done_reg;
  reg [8:0]  buf_reg;
  reg [10:0] sh_reg;
  reg [3:0]  left_reg;
  reg [3:0]  cnt_reg;
  wire       step;

  // async bit edges follow the free divide-by-16 counter
  assign step = (mode == 2'h0) ? m0_shift :
                (tick16 && cnt_reg == `FMSP_OVS_LAST);
  assign active = act_reg;
  assign done   = done_reg;
  assign line   = act_reg ? sh_reg[0] : 1'b1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pend_reg <= 1'b0;
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
      buf_reg  <= 9'h000;
      sh_reg   <= 11'h7ff;
      left_reg <= 4'h0;
      cnt_reg  <= 4'h0;
    end else begin
      done_reg <= 1'b0;
      if (tick16)
        cnt_reg <= cnt_reg + 4'h1;
      if (start) begin
        pend_reg <= 1'b1;
        buf_reg  <= {ninth, data};
      end
      if (!act_reg) begin
        if (pend_reg && step) begin
          act_reg  <= 1'b1;
          pend_reg <= start;
          case (mode)
            2'h0: begin
              sh_reg   <= {3'h7, buf_reg[7:0]};
              left_reg <= `FMSP_LEN_M0;
            end
            2'h1: begin
              sh_reg   <= {2'h3, buf_reg[7:0], 1'b0};
              left_reg <= `FMSP_LEN_M1;
            end
            default: begin
              sh_reg   <= {1'b1, buf_reg, 1'b0};
              left_reg <= `FMSP_LEN_M23;
            end
          endcase
        end
      end else if (step) begin
        sh_reg   <= {1'b1, sh_reg[10:1]};
        left_reg <= left_reg - 4'h1;
        if (left_reg == 4'h1) begin
          act_reg  <= 1'b0;
          done_reg <= 1'b1;
        end
      end
    end
  end
endmodule

/* src/fmsp_rx.v */
// Purpose: receive shifter for all four frame modes
// Assumes: rxd already synchronous to aclk
// Notes:   single mid-bit sample; a start that is gone at mid-bit
//          is treated as noise and dropped
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_rx (
  input  wire       aclk,
  input  wire       aresetn,
  input  wire [1:0] mode,
  input  wire       tick16,
  input  wire       m0_shift,
  input  wire       rxd,
  input  wire       permit,
  input  wire       m0_go,
  output wire       active,
  output wire       done,
  output reg  [7:0] data,
  output reg        bit9,
  output wire       stop_ok
);
  reg       act_reg;
  reg       done_reg;
  reg [9:0] sh_reg;
  reg [3:0] left_reg;
  reg [3:0] cnt_reg;
  reg [3:0] len_reg;

  assign active  = act_reg;
  assign done    = done_reg;
  assign stop_ok = sh_reg[9];

  always @* begin
    case (mode)
      2'h0:    data = sh_reg[9:2];
      2'h1:    data = sh_reg[8:1];
      default: data = sh_reg[7:0];
    endcase
    bit9 = (mode == 2'h1) ? sh_reg[9] : sh_reg[8];
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      act_reg  <= 1'b0;
      done_reg <= 1'b0;
      sh_reg   <= 10'h000;
      left_reg <= 4'h0;
      cnt_reg  <= 4'h0;
      len_reg  <= 4'h0;
    end else begin
      done_reg <= 1'b0;
      if (!act_reg) begin
        // done_reg guard: the flag is not yet set in this cycle
        // start on a machine cycle end so every sample follows a clock low
        if (mode == 2'h0 && m0_go && !done_reg && m0_shift) begin
          act_reg  <= 1'b1;
          left_reg <= `FMSP_LEN_M0;
        end else if (mode != 2'h0 && permit && tick16 && !rxd) begin
          act_reg  <= 1'b1;
          cnt_reg  <= 4'h1;
          len_reg  <= (mode == 2'h1) ? `FMSP_LEN_M1 : `FMSP_LEN_M23;
          left_reg <= (mode == 2'h1) ? `FMSP_LEN_M1 : `FMSP_LEN_M23;
        end
      end else if (mode == 2'h0) begin
        if (m0_shift) begin
          sh_reg   <= {rxd, sh_reg[9:1]};
          left_reg <= left_reg - 4'h1;
          if (left_reg == 4'h1) begin
            act_reg  <= 1'b0;
            done_reg <= 1'b1;
          end
        end
      end else if (tick16) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == `FMSP_OVS_MID) begin
          if (left_reg == len_reg && rxd)
            act_reg <= 1'b0;
          else begin
            sh_reg   <= {rxd, sh_reg[9:1]};
            left_reg <= left_reg - 4'h1;
            if (left_reg == 4'h1) begin
              act_reg  <= 1'b0;
              done_reg <= 1'b1;
            end
          end
        end
      end
    end
  end
endmodule

/* src/fmsp_serial_port.v */
// Purpose: four-mode serial port with an axi4-lite register slave
// Assumes: aclk is the cpu clock; timer overflow inputs are one-cycle
//          pulses from the baud source timers outside this block
// Notes:   one write and one read under way at most
//
// Behaviour
// - transmit and receive paths run at the same time, independently.
// - a second byte may arrive while the first is unread; one is lost.
// - buffer write loads transmit data; buffer read returns receive data.
// - mode 0 shifts eight bits lsb first on rxd, clock on txd, cpu/6.
// - mode 1 frame is start, eight data lsb first, stop; stop to rx ninth.
// - modes 2/3 add a ninth data bit; received ninth goes to rx ninth.
// - mode 2 rate is cpu/32, or cpu/16 with the baud doubler set.
// - mode 3 equals mode 2 except that its rate is variable.
// - every write to the buffer register starts a transmission; here a second write while one is still queued replaces the queued byte.
// - mode 0 reception starts when receive flag is 0 and permit is 1.
// - modes 1-3 reception starts on a start bit when permitted.
// - modes 2/3 with filter set flag reception only if ninth bit is 1.
// - the filter bit has no effect in mode 0.
// - mode 1 with filter set flags reception only with a valid stop.
// - control register holds mode, ninth bits and both done flags.
// - timer 1 source rate is 2^doubler/32 of its overflow rate.
// - a direction set to timer 2 uses its overflows divided by 16.
// - mode 1 sends begin after the next divide-by-16 rollover.
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
`include "fmsp_consts.vh"
module fmsp_serial_port (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  output wire [1:0]  s_axi_bresp,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [3:0]  s_axi_araddr,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  input  wire        timer1_overflow,
  input  wire        timer2_overflow,
  input  wire        rxd_in,
  output wire        rxd_out,
  output wire        rxd_oe,
  output wire        txd_out
);
  // write channel state
  reg        aw_full_reg;
  reg [3:0]  aw_addr_reg;
  reg        w_full_reg;
  reg [7:0]  w_data_reg;
  reg        w_strb_reg;
  reg        bvalid_reg;
  reg [1:0]  bresp_reg;
  // read channel state
  reg        rvalid_reg;
  reg [7:0]  rdata_reg;
  reg [1:0]  rresp_reg;
  // registers
  reg [7:0]  rx_buf_reg;
  reg [1:0]  mode_reg;
  reg        filter_reg;
  reg        permit_reg;
  reg        tx_ninth_reg;
  reg        rx_ninth_reg;
  reg        tx_flag_reg;
  reg        rx_flag_reg;
  reg [2:0]  rate_reg;
  // timing
  reg [2:0]  phase_reg;
  reg        tx_half_reg;
  reg        rx_half_reg;
  // pins
  reg        txd_reg;
  reg        rxd_out_reg;
  reg        rxd_oe_reg;

  wire       do_write;
  wire       wr_buf;
  wire       wr_ctl;
  wire       wr_rate;
  wire       m0_shift;
  wire       m0_sclk;
  wire       tx_src;
  wire       rx_src;
  wire       tx_tick16;
  wire       rx_tick16;
  wire       tx_active;
  wire       tx_done;
  wire       tx_line;
  wire       rx_active;
  wire       rx_done;
  wire [7:0] rx_data;
  wire       rx_bit9;
  wire       rx_stop;
  wire       rx_accept;
  wire [7:0] ctl_value;

  // rate source event for one direction
  function src_event;
    input [1:0] mode;
    input       t2_sel;
    input       t1_ovf;
    input       t2_ovf;
    begin
      if (mode == 2'h2)
        src_event = 1'b1;
      else if (t2_sel)
        src_event = t2_ovf;
      else
        src_event = t1_ovf;
    end
  endfunction

  // 16x tick: halve the source unless doubled or timer 2 driven
  function tick_gate;
    input [1:0] mode;
    input       t2_sel;
    input       dbl;
    input       src;
    input       half;
    begin
      if (mode == 2'h2 || !t2_sel)
        tick_gate = src && (dbl || half);
      else
        tick_gate = src;
    end
  endfunction

  function [1:0] map_resp;
    input [3:0] addr;
    begin
      if (addr == `FMSP_ADDR_BUF || addr == `FMSP_ADDR_CTL ||
          addr == `FMSP_ADDR_RATE)
        map_resp = `FMSP_RESP_OKAY;
      else
        map_resp = `FMSP_RESP_SLV;
    end
  endfunction

  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready  = !w_full_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = {24'h000000, rdata_reg};
  assign s_axi_rresp   = rresp_reg;

  assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_buf   = do_write && w_strb_reg &&
                    aw_addr_reg == `FMSP_ADDR_BUF;
  assign wr_ctl   = do_write && w_strb_reg &&
                    aw_addr_reg == `FMSP_ADDR_CTL;
  assign wr_rate  = do_write && w_strb_reg &&
                    aw_addr_reg == `FMSP_ADDR_RATE;

  assign ctl_value = {mode_reg, filter_reg, permit_reg,
                      tx_ninth_reg, rx_ninth_reg, tx_flag_reg,
                      rx_flag_reg};

  // machine cycle: shift clock low in its middle three clocks
  assign m0_shift = (phase_reg == `FMSP_M0_LAST);
  assign m0_sclk  = !(phase_reg == 3'h2 || phase_reg == 3'h3 ||
                      phase_reg == 3'h4);

  assign tx_src = src_event(mode_reg, rate_reg[`FMSP_RATE_TXT2],
                            timer1_overflow, timer2_overflow);
  assign rx_src = src_event(mode_reg, rate_reg[`FMSP_RATE_RXT2],
                            timer1_overflow, timer2_overflow);
  // separate tick paths let transmit and receive rates differ
  assign tx_tick16 = tick_gate(mode_reg, rate_reg[`FMSP_RATE_TXT2],
                               rate_reg[`FMSP_RATE_DBL], tx_src,
                               tx_half_reg);
  assign rx_tick16 = tick_gate(mode_reg, rate_reg[`FMSP_RATE_RXT2],
                               rate_reg[`FMSP_RATE_DBL], rx_src,
                               rx_half_reg);

  // a full buffer drops the new byte; filter ignored in mode 0
  assign rx_accept = rx_done && !rx_flag_reg &&
                     (mode_reg == 2'h0 || !filter_reg ||
                      (mode_reg == 2'h1 ? rx_stop : rx_bit9));

  assign rxd_out = rxd_out_reg;
  assign rxd_oe  = rxd_oe_reg;
  assign txd_out = txd_reg;

  // the shifter keeps its own copy of the byte, so no second holding
  // register is needed here and a write during a frame simply queues
  fmsp_tx u_tx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .mode     (mode_reg),
    .tick16   (tx_tick16),
    .m0_shift (m0_shift),
    .start    (wr_buf),
    .data     (w_data_reg),
    .ninth    (tx_ninth_reg),
    .active   (tx_active),
    .done     (tx_done),
    .line     (tx_line)
  );

  fmsp_rx u_rx (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .mode     (mode_reg),
    .tick16   (rx_tick16),
    .m0_shift (m0_shift),
    .rxd      (rxd_in),
    .permit   (permit_reg),
    .m0_go    (permit_reg && !rx_flag_reg),
    .active   (rx_active),
    .done     (rx_done),
    .data     (rx_data),
    .bit9     (rx_bit9),
    .stop_ok  (rx_stop)
  );

  // axi write path: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `FMSP_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_strb_reg <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= map_resp(aw_addr_reg);
      end else if (bvalid_reg && s_axi_bready)
        bvalid_reg <= 1'b0;
    end
  end

  // axi read path: buffer read returns the receive side
  // reads have no side effects; flags clear only by a control write
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 8'h00;
      rresp_reg  <= `FMSP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= map_resp(s_axi_araddr);
      case (s_axi_araddr)
        `FMSP_ADDR_BUF:  rdata_reg <= rx_buf_reg;
        `FMSP_ADDR_CTL:  rdata_reg <= ctl_value;
        `FMSP_ADDR_RATE: rdata_reg <= {5'h00, rate_reg};
        default:         rdata_reg <= 8'h00;
      endcase
    end else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  // control, flags and receive buffer
  // a buffer write goes straight to the transmit shifter
  always @(posedge aclk) begin
    if (!aresetn) begin
      {mode_reg, filter_reg, permit_reg, tx_ninth_reg} <= 5'h00;
      rx_ninth_reg <= 1'b0;
      tx_flag_reg  <= 1'b0;
      rx_flag_reg  <= 1'b0;
      rate_reg     <= `FMSP_RATE_RST;
      rx_buf_reg   <= 8'h00;
    end else begin
      if (wr_rate)
        rate_reg <= w_data_reg[2:0];
      if (wr_ctl) begin
        mode_reg     <= w_data_reg[`FMSP_CTL_MODE+1:`FMSP_CTL_MODE];
        filter_reg   <= w_data_reg[`FMSP_CTL_FLT];
        permit_reg   <= w_data_reg[`FMSP_CTL_REN];
        tx_ninth_reg <= w_data_reg[`FMSP_CTL_TX9];
      end
      // hardware set wins over a software clear in the same cycle
      tx_flag_reg <= tx_done || (wr_ctl ?
                     w_data_reg[`FMSP_CTL_TXF] : tx_flag_reg);
      rx_flag_reg <= rx_accept || (wr_ctl ?
                     w_data_reg[`FMSP_CTL_RXF] : rx_flag_reg);
      if (rx_accept) begin
        rx_buf_reg <= rx_data;
        if (mode_reg != 2'h0)
          rx_ninth_reg <= rx_bit9;
      end else if (wr_ctl)
        rx_ninth_reg <= w_data_reg[`FMSP_CTL_RX9];
    end
  end

  // machine cycle phase and rate prescalers
  always @(posedge aclk) begin
    if (!aresetn) begin
      phase_reg   <= 3'h0;
      tx_half_reg <= 1'b0;
      rx_half_reg <= 1'b0;
    end else begin
      phase_reg <= m0_shift ? 3'h0 : phase_reg + 3'h1;
      if (tx_src)
        tx_half_reg <= !tx_half_reg;
      if (rx_src)
        rx_half_reg <= !rx_half_reg;
    end
  end

  // pins: mode 0 drives data on rxd and the shift clock on txd
  always @(posedge aclk) begin
    if (!aresetn) begin
      txd_reg     <= 1'b1;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg  <= 1'b0;
    end else if (mode_reg == 2'h0) begin
      txd_reg     <= (tx_active || rx_active) ? m0_sclk : 1'b1;
      rxd_out_reg <= tx_line;
      rxd_oe_reg  <= tx_active;
    end else begin
      txd_reg     <= tx_line;
      rxd_out_reg <= 1'b1;
      rxd_oe_reg  <= 1'b0;
    end
  end
endmodule

/* tb/fmsp_checker.sv */
// Purpose: port-level assertions for the serial port
// Assumes: single clock domain, synchronous active-low reset
// Notes:   mode is internal, so pin checks key off rxd_oe
`timescale 1ns/100ps
module fmsp_checker (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [3:0]  s_axi_araddr,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        rxd_out,
  input wire        rxd_oe,
  input wire        txd_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer lost");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer lost");
  a_read_delay: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  a_write_delay: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("bvalid late");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 4'hc |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rdata_upper: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_pin_release: assert property (!rxd_oe |-> rxd_out)
    else $error("rxd driven low while released");
  a_reset_idle: assert property ($rose(aresetn) |->
    txd_out && rxd_out && !rxd_oe) else $error("pins not idle after reset");
  a_shift_low: assert property (rxd_oe && $fell(txd_out) |->
    !txd_out [*3] ##1 txd_out) else $error("shift clock low phase wrong");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_shift: cover property (rxd_oe && $fell(txd_out));
endmodule

bind fmsp_serial_port fmsp_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out));

/* tb/fmsp_far_end.sv */
// Purpose: remote serial device facing the port
// Assumes: line has a pull-up, so a released line reads high
// Notes:   frames are passed lsb first with start and stop included
`timescale 1ns/100ps
module fmsp_far_end (
  input  wire  aclk,
  input  wire  txd,
  input  wire  rxd_oe,
  input  wire  rxd_drv,
  output logic rxd
);
  initial rxd = 1'b1;

  task send(input [10:0] f, input int n, input int per);
    @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= f[i];
      repeat (per) @(posedge aclk);
    end
    rxd <= 1'b1;
  endtask

  task recv(input int per, input int n, output logic [10:0] f);
    f = '0;
    @(negedge txd);
    repeat (per / 2) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (per) @(posedge aclk);
    end
  endtask

  // sample on the rising shift clock, data moves at cycle end
  task recv0(output logic [7:0] b, output int span);
    time t0;
    t0 = 0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txd iff rxd_oe);
      b[i] = rxd_drv;
      if (i == 0) t0 = $time;
    end
    span = int'(($time - t0) / 5);
  endtask

  task send0(input [7:0] b);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      rxd <= b[i];
    end
    repeat (6) @(posedge aclk);
    rxd <= 1'b1;
  endtask
endmodule

/* tb/tb.sv */
// Purpose: self-checking bench for the four-mode serial port
// Assumes: timer overflows pulse every other clock
// Notes:   tx from timer 1 runs at 64 clocks a bit, timer 2 at 32
`timescale 1ns/100ps
module tb;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        ph, t1, t2, awready, wready, bvalid, arready, rvalid;
  logic        rxd_out, rxd_oe, txd;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [10:0] v;
  logic [7:0]  b;
  wire         far_rxd;
  wire         rxd_pin = rxd_oe ? rxd_out : far_rxd;
  int          n_fail = 0;
  int          total_checks = 0;
  int          span;

  fmsp_serial_port dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .timer1_overflow(t1),
    .timer2_overflow(t2), .rxd_in(rxd_pin), .rxd_out(rxd_out),
    .rxd_oe(rxd_oe), .txd_out(txd));
  fmsp_far_end far (.aclk(aclk), .txd(txd), .rxd_oe(rxd_oe),
    .rxd_drv(rxd_out), .rxd(far_rxd));

  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    ph <= ~ph;
    t1 <= ph;
    t2 <= ph;
  end

  task finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input [31:0] s, input [31:0] e);
    total_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task axi_write(input [3:0] a, input [31:0] d, output [1:0] r);
    logic pa, pw, pb;
    pa = 1;
    pw = 1;
    pb = 1;
    @(posedge aclk);
    {awvalid, wvalid, bready} <= 3'h7;
    {awaddr, wdata, wstrb} <= {a, d, 4'hf};
    while (pa | pw | pb) begin
      @(posedge aclk);
      if (pb && bvalid) r = bresp;
      pb = pb && !bvalid;
      pa = pa && !awready;
      pw = pw && !wready;
      {awvalid, wvalid, bready} <= {pa, pw, pb};
    end
  endtask

  task axi_read(input [3:0] a, output [31:0] d, output [1:0] r);
    logic pa, pr;
    pa = 1;
    pr = 1;
    @(posedge aclk);
    {arvalid, rready, araddr} <= {2'h3, a};
    while (pa | pr) begin
      @(posedge aclk);
      if (pr && rvalid) {d, r} = {rdata, rresp};
      pr = pr && !rvalid;
      pa = pa && !arready;
      {arvalid, rready} <= {pa, pr};
    end
  endtask

  task wr(input [3:0] a, input [31:0] d, input [1:0] e = 2'h0);
    logic [1:0] r;
    axi_write(a, d, r);
    check(r, e);
  endtask

  task rd(input [3:0] a, input [31:0] e, input [1:0] er = 2'h0);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check(d, e);
    check(r, er);
  endtask

  task poll(input [31:0] m);
    logic [31:0] d;
    logic [1:0]  r;
    for (int k = 0; k < 400; k++) begin
      axi_read(4'h4, d, r);
      if ((d & m) === m) break;
    end
  endtask

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, ph} = '0;
    {awaddr, araddr, wstrb, wdata, t1, t2} = '0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(4'h4, 32'h0);
    rd(4'h8, 32'h0);
    rd(4'hc, 32'h0, 2'h2);
    wr(4'hc, 32'h55, 2'h2);
    $display("test reset done");
    for (int dbl = 0; dbl < 2; dbl++) begin
      wr(4'h8, dbl);
      wr(4'h4, 32'h88);
      fork
        far.recv(dbl ? 16 : 32, 11, v);
        wr(4'h0, 32'ha5);
      join
      check(v, {1'b1, 1'b1, 8'ha5, 1'b0});
      poll(32'h2);
      rd(4'h4, 32'h8a);
    end
    $display("test mode 2 transmit done");
    wr(4'h8, 32'h0);
    wr(4'h4, 32'hf0);
    far.send({1'b1, 1'b0, 8'h3c, 1'b0}, 11, 64);
    rd(4'h4, 32'hf0);
    far.send({1'b1, 1'b1, 8'h5a, 1'b0}, 11, 64);
    poll(32'h1);
    rd(4'h4, 32'hf5);
    far.send({1'b1, 1'b1, 8'h77, 1'b0}, 11, 64);
    rd(4'h0, 32'h5a);
    $display("test mode 3 filter done");
    wr(4'h8, 32'h4);
    wr(4'h4, 32'h70);
    fork
      far.send({1'b1, 8'hc3, 1'b0}, 10, 32);
      far.recv(64, 10, v);
      wr(4'h0, 32'h96);
    join
    check(v, {1'b0, 1'b1, 8'h96, 1'b0});
    poll(32'h3);
    rd(4'h4, 32'h77);
    rd(4'h0, 32'hc3);
    wr(4'h4, 32'h70);
    far.send({1'b0, 8'h11, 1'b0}, 10, 32);
    rd(4'h4, 32'h70);
    // a low stop bit holds the line low, so a second start follows
    repeat (320) @(posedge aclk);
    $display("test mode 1 duplex done");
    wr(4'h4, 32'h20);
    fork
      far.recv0(b, span);
      wr(4'h0, 32'h6d);
    join
    check(b, 8'h6d);
    check(span, 42);
    poll(32'h2);
    fork
      far.send0(8'hb4);
      wr(4'h4, 32'h30);
    join
    poll(32'h1);
    rd(4'h4, 32'h31);
    rd(4'h0, 32'hb4);
    $display("test mode 0 done");
    finish_test;
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    finish_test;
  end
endmodule
